// ### bench/mfrd_issuer.sv
// Pipeline front end model issuing instructions to the decoder.
`timescale 1ns/1ps
`default_nettype none

module mfrd_issuer
   import mfrd_pkg::*;
(
   output var logic issue_valid,
   output var logic [31:0] issue_instr,
   output var logic [31:0] base_value,
   output var logic [31:0] index_value
);
   // Port starts idle with no instruction on it.
   initial begin
      issue_valid = 1'b0;
      issue_instr = 32'h0000_0000;
      base_value = 32'h0000_0000;
      index_value = 32'h0000_0000;
   end

   // Caller stands just after a falling edge, so back to back is free.
   task automatic send(input logic [31:0] i, input logic [31:0] b,
      input logic [31:0] x);
      issue_valid = 1'b1;
      issue_instr = i;
      base_value = b;
      index_value = x;
   endtask : send

   // Released operands flip so stale values never look like live ones.
   task automatic idle();
      issue_valid = 1'b0;
      issue_instr = ~issue_instr;
      base_value = ~base_value;
      index_value = ~index_value;
   endtask : idle

   // One-field condition read always carries a single mask bit.
   function automatic logic [31:0] cond_instr(input logic [4:0] t,
      input int k);
      logic [7:0] m;
      m = 8'h80 >> k;
      return {OPC_PRIMARY, t, 1'b1, m, 1'b0, XO_COND, 1'b0};
   endfunction : cond_instr
endmodule : mfrd_issuer

`default_nettype wire

// ### bench/mfrd_top_tb.sv
// Self-checking bench for the move-from decoder.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module mfrd_top_tb;
   import mfrd_pkg::*;
   logic ref_clk, rst, clk_en, supervisor, arch_original;
   logic issue_valid;
   logic [31:0] issue_instr, base_value, index_value;
   logic [31:0] cond_value, xer_value, msr_value, bv, xv, s;
   logic [447:0] spr_values;
   logic [511:0] seg_values;
   logic gpr_we_q, base_we_q, priv_exc_q, illegal_q, cond0_undef_q;
   logic [4:0] gpr_waddr_q, base_waddr_q;
   logic [31:0] gpr_wdata_q, base_wdata_q;
   int bad_count = 0;
   int checked = 0;

   mfrd_issuer iss (.issue_valid(issue_valid), .issue_instr(issue_instr),
      .base_value(base_value), .index_value(index_value));

   mfrd_top dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .issue_valid(issue_valid), .issue_instr(issue_instr),
      .supervisor(supervisor), .arch_original(arch_original),
      .cond_value(cond_value), .xer_value(xer_value),
      .msr_value(msr_value), .spr_values(spr_values),
      .seg_values(seg_values), .base_value(base_value),
      .index_value(index_value), .gpr_we_q(gpr_we_q),
      .gpr_waddr_q(gpr_waddr_q), .gpr_wdata_q(gpr_wdata_q),
      .base_we_q(base_we_q), .base_waddr_q(base_waddr_q),
      .base_wdata_q(base_wdata_q), .priv_exc_q(priv_exc_q),
      .illegal_q(illegal_q), .cond0_undef_q(cond0_undef_q));

   // Free-running clock, 4 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      if (bad_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done

   function automatic logic [31:0] mk(input logic [9:0] xo,
      input logic [4:0] t, input logic [4:0] a, input logic [4:0] b,
      input logic rc);
      return {OPC_PRIMARY, t, a, b, xo, rc};
   endfunction : mk

   // Issues one word and checks its single-cycle answer; flg is
   // {privilege fault, undefined, field 0 undefined}.
   task automatic run(input logic [31:0] i, input logic we,
      input logic [31:0] wd, input logic bwe, input logic [31:0] bwd,
      input logic [2:0] flg);
      iss.send(i, bv, xv);
      @(negedge ref_clk);
      `CHK(gpr_we_q, we)
      if (we) `CHK({gpr_waddr_q, gpr_wdata_q}, {i[25:21], wd})
      `CHK(base_we_q, bwe)
      if (bwe) `CHK({base_waddr_q, base_wdata_q}, {i[20:16], bwd})
      `CHK({priv_exc_q, illegal_q, cond0_undef_q}, flg)
   endtask : run

   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      test_done();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      int k;
      logic [4:0] t, a;
      logic rc;
      logic [9:0] n;
      void'($urandom(53950));
      {rst, clk_en, supervisor, arch_original} = 4'hd;
      {cond_value, xer_value, msr_value} = {$urandom(), $urandom(),
         $urandom()};
      for (k = 0; k < 16; k++) seg_values[k*32 +: 32] = $urandom();
      for (k = 0; k < 14; k++) spr_values[k*32 +: 32] = $urandom();
      {bv, xv} = 64'h0;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      for (k = 0; k < 8; k++) begin
         cond_value = $urandom();
         run(iss.cond_instr(5'($urandom()), k), 1'b1, cond_value &
            (32'hf000_0000 >> (4 * k)), 1'b0, 0, 3'h0);
      end
      for (k = 0; k < SPR_COUNT; k++) begin
         n = SPR_NUMS[k];
         s = (k == 0) ? xer_value : spr_values[(k-(k>0))*32 +: 32];
         run(mk(XO_SPR, 5'($urandom()), n[4:0], n[9:5], 1'b0), 1'b1, s,
            1'b0, 0, 3'h0);
      end
      run(mk(XO_SPR, 5'h3, 5'h2, 5'h0, 1'b0), 1'b0, 0, 1'b0, 0,
         3'h2);
      for (k = 0; k < 8; k++) begin
         rc = k[0];
         run(mk(XO_SEG, 5'($urandom()), {1'b0, 3'(k), 1'b0}, 5'h0, rc),
            1'b1, seg_values[k*32 +: 32], 1'b0, 0, {2'b0, rc});
      end
      // Privilege only bites in the newer variant, so leave the original.
      {supervisor, arch_original} = 2'b00;
      run(mk(XO_SEG, 5'h4, 5'h2, 5'h0, 1'b0), 1'b0, 0, 1'b0, 0,
         3'h4);
      run(mk(XO_MSTATE, 5'h4, 5'h0, 5'h0, 1'b0), 1'b0, 0, 1'b0, 0,
         3'h4);
      supervisor = 1'b1;
      run(mk(XO_SEG, 5'h4, 5'h2, 5'h0, 1'b0), 1'b1, seg_values[32 +: 32],
         1'b0, 0, 3'h0);
      run(mk(XO_MSTATE, 5'h5, 5'h0, 5'h0, 1'b0), 1'b1, msr_value, 1'b0,
         0, 3'h0);
      {supervisor, arch_original} = 2'b01;
      run(mk(XO_MSTATE, 5'h9, 5'h0, 5'h0, 1'b0), 1'b1, msr_value, 1'b0,
         0, 3'h0);
      for (k = 0; k < 12; k++) begin
         t = 5'($urandom());
         a = (k == 0) ? 5'h0 : (k == 1) ? t : 5'($urandom());
         rc = 1'($urandom());
         {bv, xv} = {$urandom(), $urandom()};
         s = ((a == 5'h0) ? 32'h0 : bv) + xv;
         run(mk(XO_SEG_IND, t, a, 5'($urandom()), rc),
            1'b1, seg_values[s[31:28]*32 +: 32], a != 5'h0 && a != t, s,
            {2'b0, rc});
      end
      arch_original = 1'b0;
      run(mk(XO_SEG_IND, 5'h6, 5'h5, 5'h4, 1'b0), 1'b0, 0, 1'b0, 0,
         3'h2);
      run(mk(10'h090, 5'h6, 5'h5, 5'h4, 1'b0), 1'b0, 0, 1'b0, 0,
         3'h0);
      clk_en = 1'b0;
      run(iss.cond_instr(5'h7, 0), 1'b0, 0, 1'b0, 0, 3'h0);
      clk_en = 1'b1;
      run(iss.cond_instr(5'h7, 0), 1'b1, cond_value & 32'hf000_0000, 1'b0,
         0, 3'h0);
      iss.idle();
      @(negedge ref_clk);
      `CHK(gpr_we_q, 1'b0)
      test_done();
   end
endmodule : mfrd_top_tb

`undef CHK
`default_nettype wire

// ### rtl/mfrd_pkg.sv
// Constants, decode types and the condition field selector for move-from.
// -----------------------------------------------------------------------
// How it works
// RULE_01 - Opcode 31, bit 11 set, extended 19 copies one mask-chosen field.
// RULE_02 - Mask bits 12..19 pick condition slices 00-03..28-31 at same place.
// RULE_03 - Issuer gives exactly one mask bit; several bits is undefined.
// RULE_04 - None of these moves alters the fixed-point exception register.
// RULE_05 - Opcode 31, extended 339 copies a special register to target.
// RULE_06 - The ten-bit special register number has its halves swapped.
// RULE_07 - Readable numbers: 1,8,9,18,19,22,25,26,27,272-275,282,284.
// RULE_08 - Special register 1 returns the fixed-point exception register.
// RULE_09 - Extended 595 copies segment register from bits 12-14 to target.
// RULE_10 - Segment reads with record bit leave condition field 0 undefined.
// RULE_11 - Direct segment and machine state reads privileged in newer variant.
// RULE_12 - Indirect segment read, extended 627, exists in original only.
// RULE_13 - Indirect read picks segment register by top four bits of sum.
// RULE_14 - Nonzero base field: base plus index is written back to base.
// RULE_15 - Base field equal to target field suppresses the base write.
// RULE_16 - Extended 83 copies machine state, condition field 0 untouched.
// RULE_17 - One-field condition read writes zero outside selected slice.
// RULE_18 - Unprivileged privileged read updates nothing, raises exception.
// -----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

package mfrd_pkg;
   // -----------------------------------------------------------------
   // Opcodes and field positions (bit 0 of the word is the LSB here).
   // -----------------------------------------------------------------
   localparam logic [5:0] OPC_PRIMARY = 6'h1f;
   localparam logic [9:0] XO_COND = 10'h013;
   localparam logic [9:0] XO_SPR = 10'h153;
   localparam logic [9:0] XO_SEG = 10'h253;
   localparam logic [9:0] XO_SEG_IND = 10'h273;
   localparam logic [9:0] XO_MSTATE = 10'h053;
   localparam int OPC_LSB = 26;
   localparam int TGT_LSB = 21;
   localparam int BASE_LSB = 16;
   localparam int IDX_LSB = 11;
   localparam int ONE_FIELD_BIT = 20;
   localparam int MASK_LSB = 12;
   localparam int SEGNUM_LSB = 17;
   localparam int XO_LSB = 1;
   localparam int RECORD_BIT = 0;
   localparam int SPR_LO_LSB = 16;
   localparam int SPR_HI_LSB = 11;
   localparam logic [31:0] WDATA_RST = 32'h0000_0000;
   localparam logic [4:0] WADDR_RST = 5'h00;
   // Accepted special register numbers; entry 0 is the exception register.
   localparam int SPR_COUNT = 15;
   localparam logic [9:0] SPR_NUMS [SPR_COUNT] = '{
      10'h001, 10'h008, 10'h009, 10'h012, 10'h013, 10'h016, 10'h019,
      10'h01a, 10'h01b, 10'h110, 10'h111, 10'h112, 10'h113, 10'h11a,
      10'h11c};

   typedef enum logic [2:0] {
      K_NONE, K_COND, K_SPR, K_SEG, K_SEG_IND, K_MSTATE
   } mfrd_kind_t;
endpackage : mfrd_pkg

// Picks the masked four-bit condition slices, zeros elsewhere.
module mfrd_field_sel (
   input wire logic [7:0] field_mask,
   input wire logic [31:0] cond_word,
   output logic [31:0] cond_slice
);
   // Mask bit k (leftmost first) owns the k-th nibble from the top.
   for (genvar k = 0; k < 8; k++) begin : g_field
      assign cond_slice[31-4*k -: 4] =
         field_mask[7-k] ? cond_word[31-4*k -: 4] : 4'h0; // [RULE_02] [RULE_17]
   end
endmodule : mfrd_field_sel

`default_nettype wire

// ### rtl/mfrd_top.sv
// Decode and execute of the move-from condition, special and segment group.
`timescale 1ns/1ps
`default_nettype none

module mfrd_top
   import mfrd_pkg::*;
#(
   parameter int XLEN = 32,
   parameter int SR_COUNT = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   input wire logic supervisor,
   input wire logic arch_original,
   input wire logic [31:0] cond_value,
   input wire logic [XLEN-1:0] xer_value,
   input wire logic [XLEN-1:0] msr_value,
   input wire logic [(SPR_COUNT-1)*XLEN-1:0] spr_values,
   input wire logic [SR_COUNT*XLEN-1:0] seg_values,
   input wire logic [XLEN-1:0] base_value,
   input wire logic [XLEN-1:0] index_value,
   output logic gpr_we_q,
   output logic [4:0] gpr_waddr_q,
   output logic [XLEN-1:0] gpr_wdata_q,
   output logic base_we_q,
   output logic [4:0] base_waddr_q,
   output logic [XLEN-1:0] base_wdata_q,
   output logic priv_exc_q,
   output logic illegal_q,
   output logic cond0_undef_q
);

   // -----------------------------------------------------------------
   // Field extraction.
   // -----------------------------------------------------------------
   logic [5:0] opc;
   logic [9:0] xo;
   logic [4:0] target_gpr;
   logic [4:0] base_gpr;
   logic [7:0] field_select_mask;
   logic [2:0] segment_register_number;
   logic [9:0] spr_num;
   logic record_bit;
   logic one_field;

   assign opc = issue_instr[OPC_LSB +: 6];
   assign xo = issue_instr[XO_LSB +: 10];
   assign target_gpr = issue_instr[TGT_LSB +: 5];
   assign base_gpr = issue_instr[BASE_LSB +: 5];
   assign field_select_mask = issue_instr[MASK_LSB +: 8];
   assign segment_register_number = issue_instr[SEGNUM_LSB +: 3];
   assign record_bit = issue_instr[RECORD_BIT];
   assign one_field = issue_instr[ONE_FIELD_BIT];
   // The number is stored low half first, so swap back before lookup.
   assign spr_num = {issue_instr[SPR_HI_LSB +: 5],
                     issue_instr[SPR_LO_LSB +: 5]}; // [RULE_06]

   // -----------------------------------------------------------------
   // Instruction classification.
   // -----------------------------------------------------------------
   mfrd_kind_t kind;

   // Only opcode 31 with one of our extended codes belongs to this block.
   always_comb begin
      kind = K_NONE;
      if (opc == OPC_PRIMARY) begin
         unique case (xo)
            XO_COND: kind = K_COND; // [RULE_01]
            XO_SPR: kind = K_SPR; // [RULE_05]
            XO_SEG: kind = K_SEG; // [RULE_09]
            XO_SEG_IND: kind = K_SEG_IND;
            XO_MSTATE: kind = K_MSTATE; // [RULE_16]
            default: kind = K_NONE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Special register lookup.
   // -----------------------------------------------------------------
   logic [SPR_COUNT-1:0] spr_hit;
   logic [XLEN-1:0] spr_word [SPR_COUNT];

   // One comparator per accepted number; others never hit.
   for (genvar i = 0; i < SPR_COUNT; i++) begin : g_spr
      assign spr_hit[i] = (spr_num == SPR_NUMS[i]); // [RULE_07]
      if (i == 0) begin : g_xer
         assign spr_word[i] = xer_value; // [RULE_08]
      end else begin : g_other
         assign spr_word[i] = spr_values[(i-1)*XLEN +: XLEN];
      end
   end

   logic [XLEN-1:0] spr_data;

   // Numbers are distinct, so at most one hit and an OR-mux suffices.
   always_comb begin
      spr_data = '0;
      for (int i = 0; i < SPR_COUNT; i++) begin
         if (spr_hit[i]) begin
            spr_data = spr_data | spr_word[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // Operand paths.
   // -----------------------------------------------------------------
   logic [31:0] cond_slice;
   logic [XLEN-1:0] ind_sum;
   logic [3:0] ind_seg;

   mfrd_field_sel u_field_sel (
      .field_mask(field_select_mask),
      .cond_word(cond_value),
      .cond_slice(cond_slice)
   );

   // A zero base field means a zero base, not general register 0.
   assign ind_sum = ((base_gpr == 5'h00) ? '0 : base_value)
                    + index_value; // [RULE_14]
   assign ind_seg = ind_sum[XLEN-1 -: 4]; // [RULE_13]

   // -----------------------------------------------------------------
   // Legality and result.
   // -----------------------------------------------------------------
   logic priv_fault;
   logic undef_op;
   logic commit;
   logic base_wb;
   logic [XLEN-1:0] result;

   // Privilege applies only to the newer variant.
   assign priv_fault = (kind == K_SEG || kind == K_MSTATE)
                       && !arch_original && !supervisor; // [RULE_11]
   assign undef_op = (kind == K_SEG_IND && !arch_original) // [RULE_12]
                     || (kind == K_SPR && spr_hit == '0); // [RULE_07]
   assign commit = issue_valid && kind != K_NONE
                   && !priv_fault && !undef_op; // [RULE_18]
   assign base_wb = kind == K_SEG_IND && base_gpr != 5'h00
                    && base_gpr != target_gpr; // [RULE_14] [RULE_15]

   // The full-register form with bit 11 clear is kept for completeness.
   always_comb begin
      result = '0;
      unique case (kind)
         K_COND: result = XLEN'(one_field ? cond_slice
                                          : cond_value); // [RULE_01]
         K_SPR: result = spr_data; // [RULE_05]
         K_SEG: result = seg_values[segment_register_number*XLEN +: XLEN];
         K_SEG_IND: result = seg_values[ind_seg*XLEN +: XLEN]; // [RULE_13]
         K_MSTATE: result = msr_value; // [RULE_16]
         K_NONE: result = '0;
      endcase
   end

   // -----------------------------------------------------------------
   // Target register write port.
   // -----------------------------------------------------------------
   // There is no exception register write port at all, so it cannot move.
   always_ff @(posedge ref_clk) begin // [RULE_04]
      if (rst) begin
         gpr_we_q <= 1'b0;
         gpr_waddr_q <= WADDR_RST;
         gpr_wdata_q <= XLEN'(WDATA_RST);
      end else if (clk_en) begin
         gpr_we_q <= commit; // [RULE_18]
         if (commit) begin
            gpr_waddr_q <= target_gpr;
            gpr_wdata_q <= result;
         end
      end
   end

   // -----------------------------------------------------------------
   // Base register write-back.
   // -----------------------------------------------------------------
   // Separate port so the segment value and the sum land in one cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         base_we_q <= 1'b0;
         base_waddr_q <= WADDR_RST;
         base_wdata_q <= XLEN'(WDATA_RST);
      end else if (clk_en) begin
         base_we_q <= commit && base_wb; // [RULE_14] [RULE_15]
         if (commit && base_wb) begin
            base_waddr_q <= base_gpr;
            base_wdata_q <= ind_sum;
         end
      end
   end

   // -----------------------------------------------------------------
   // Status toward the pipeline.
   // -----------------------------------------------------------------
   // Field 0 is never written; the flag only tells the pipeline it is void.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         priv_exc_q <= 1'b0;
         illegal_q <= 1'b0;
         cond0_undef_q <= 1'b0;
      end else if (clk_en) begin
         priv_exc_q <= issue_valid && priv_fault; // [RULE_18]
         illegal_q <= issue_valid && undef_op; // [RULE_12]
         cond0_undef_q <= commit && record_bit
                          && (kind == K_SEG || kind == K_SEG_IND); // [RULE_10]
      end
   end

   // -----------------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_one_field_cr: assert property ( // [RULE_01] [RULE_02] [RULE_17]
      clk_en && commit && kind == K_COND && one_field
      && field_select_mask == 8'h80
      |=> gpr_we_q && gpr_wdata_q[27:0] == 28'h0
          && gpr_wdata_q[31:28] == $past(cond_value[31:28]))
      else $error("one-field condition read gave wrong word");
   a_spr_xer_read: assert property ( // [RULE_06] [RULE_08]
      clk_en && issue_valid && kind == K_SPR
      && issue_instr[20:11] == 10'h020
      |=> gpr_we_q && gpr_wdata_q == $past(xer_value))
      else $error("special register 1 did not return exception register");
   a_spr_reject: assert property ( // [RULE_07]
      clk_en && issue_valid && kind == K_SPR && spr_hit == '0
      |=> illegal_q && !gpr_we_q)
      else $error("unlisted special register number was accepted");
   a_seg_direct: assert property ( // [RULE_09]
      clk_en && commit && kind == K_SEG
      |=> gpr_wdata_q == $past(seg_values[segment_register_number*XLEN
                                          +: XLEN]))
      else $error("direct segment read returned wrong register");
   a_priv_block: assert property ( // [RULE_11] [RULE_18]
      clk_en && issue_valid && kind == K_MSTATE && !arch_original
      && !supervisor
      |=> priv_exc_q && !gpr_we_q && !base_we_q)
      else $error("privileged read went through without privilege");
   a_ind_undef: assert property ( // [RULE_12]
      clk_en && issue_valid && kind == K_SEG_IND && !arch_original
      |=> illegal_q && !gpr_we_q && !base_we_q)
      else $error("indirect segment read executed in newer variant");
   a_ind_wb_sum: assert property ( // [RULE_14]
      clk_en && commit && kind == K_SEG_IND && base_gpr != 5'h00
      && base_gpr != target_gpr
      |=> base_we_q && base_wdata_q == $past(base_value)
          + $past(index_value))
      else $error("indirect base write-back sum wrong or missing");
   a_ind_same_tgt: assert property ( // [RULE_15]
      clk_en && commit && kind == K_SEG_IND && base_gpr == target_gpr
      |=> !base_we_q && gpr_we_q)
      else $error("base write-back not suppressed when base equals target");
   a_msr_copy: assert property ( // [RULE_16]
      clk_en && commit && kind == K_MSTATE
      |=> gpr_wdata_q == $past(msr_value) && !cond0_undef_q)
      else $error("machine state read wrong or touched field 0");
   a_rec_flag: assert property ( // [RULE_10]
      clk_en && commit && kind == K_SEG && record_bit |=> cond0_undef_q)
      else $error("record bit on segment read did not flag field 0");

   c_one_field: cover property (clk_en && commit && kind == K_COND
                                && one_field);
   c_ind_wb: cover property (clk_en && commit && kind == K_SEG_IND
                             && base_wb);
   c_priv_trap: cover property (clk_en && issue_valid && priv_fault);

endmodule : mfrd_top

`default_nettype wire
